// ---- hw/mpm_blank_filter.v ----
`timescale 1ns/1ps
`include "mpm_consts.vh"
// blanking window after turn-on, then N consecutive over-limit samples
module mpm_blank_filter #(
    parameter STEP_CYC = 8
) (
    input wire ref_clk,
    input wire reset_n,
    input wire pwmOnStart,
    input wire [2:0] blankingWindowLength,
    input wire [2:0] feedbackSampleCount,
    input wire compSync,
    output reg limitEvent
);
    reg [12:0] blankCnt; // cycles of blanking left
    reg [1:0] sampleDiv; // divide-by-four sample strobe
    reg [3:0] hitCnt; // consecutive over-limit samples
    wire sampleTick = (sampleDiv == 2'h3);
    wire blanking = (blankCnt != 13'h0000);
    wire [3:0] needed = {1'b0, feedbackSampleCount} + 4'h1;

    // blanking window restarts at every turn-on
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            blankCnt <= 13'h0000;
        end else if (pwmOnStart) begin
            blankCnt <= blankingWindowLength * STEP_CYC[9:0];
        end else if (blanking) begin
            blankCnt <= blankCnt - 13'h0001;
        end
    end

    // sample once per four clocks and count a run of hits
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sampleDiv <= 2'h0;
            hitCnt <= 4'h0;
            limitEvent <= 1'b0;
        end else begin
            sampleDiv <= sampleDiv + 2'h1;
            limitEvent <= 1'b0;
            if (pwmOnStart || blanking) begin
                hitCnt <= 4'h0; // comparator ignored
            end else if (sampleTick) begin
                if (!compSync) begin
                    hitCnt <= 4'h0; // run broken
                end else if (hitCnt + 4'h1 >= needed) begin
                    hitCnt <= 4'h0;
                    limitEvent <= 1'b1;
                end else begin
                    hitCnt <= hitCnt + 4'h1;
                end
            end
        end
    end
endmodule // mpm_blank_filter

// ---- hw/mpm_pwm_manager.v ----
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "mpm_consts.vh"
// How it works
// - voltage mode uses generator phase U compare
// - voltage mode comparator sets current-limit flag
// - interrupt needs mask and flag both set
// - action select only with voltage-mode enable
// - action clear: only PWM forced off
// - action set: master output enable cleared
// - reset state is high-z or low
// - resulting PWM goes to channel manager
// - current mode combines window and comparator
// - reference from enabled phase U/V/W compare
// - blanking window ignores comparator after turn-on
// - event counter filters first comparator edge
// - blanking code steps 0.5 us, 000 off
// - code plus one consecutive samples needed
// - comparator sampled every four clocks
// - on at window end, off at start/limit
module mpm_pwm_manager #(
    parameter PERIPH_MHZ = `MPM_REF_PERIPH_MHZ,
    parameter CHANNELS = 6
) (
    input wire ref_clk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire phaseUCompare,
    input wire phaseVCompare,
    input wire phaseWCompare,
    input wire currentComparator,
    input wire [CHANNELS-1:0] channelSelect,
    output reg pwmToChannels,
    output reg [CHANNELS-1:0] motorOutputChannels,
    output reg [CHANNELS-1:0] motorOutputEnable,
    output reg currentReferenceOut,
    output wire irq
);
    // clocks per 0.5 us blanking step, scaled by periph ratio
    localparam STEP_NS_SCALED =
        (`MPM_BLANK_STEP_NS * `MPM_REF_PERIPH_MHZ) / PERIPH_MHZ;
    localparam STEP_CYC_RAW =
        (STEP_NS_SCALED + `MPM_CLK_PERIOD_NS - 1) / `MPM_CLK_PERIOD_NS;
    localparam STEP_CYC = (STEP_CYC_RAW < 1) ? 1 : STEP_CYC_RAW;
    // pwm states, one-hot
    localparam ST_OFF = 2'b01;
    localparam ST_ON = 2'b10;

    reg currentModeSelect; // 1 = current mode
    reg currentLimitIrqEnable; // voltage-mode enable
    reg overcurrentActionSelect; // 1 = drop all outputs
    reg masterOutputEnable; // global drive enable
    reg disabledStateSelect; // 1 = drive low, 0 = high-z
    reg [2:0] refEnable; // phase w,v,u reference enables
    reg [7:0] comparatorFilterReg; // blanking and count codes
    reg [1:0] status; // sticky events
    reg [1:0] mask; // interrupt mask
    reg [15:0] windowPeriod; // window length in clocks, minus one
    reg compMeta; // synchroniser first stage
    reg compSync; // synchronised comparator
    reg [1:0] state; // current-mode pwm state
    reg [1:0] next_state;
    reg pwmOnStart; // filter hold, high while pwm off
    reg [CHANNELS-1:0] next_outputs;
    reg [CHANNELS-1:0] next_enables;
    reg next_pwm;
    wire limitEvent;
    wire windowEnd;
    wire wrEn;
    wire rdEn;
    wire addrOk;
    wire climIrq;

    // decode of a mapped register offset
    function isMapped;
        input [11:0] a;
        begin
            isMapped = (a == `MPM_ADDR_CTRL_A) || (a == `MPM_ADDR_CTRL_B) ||
                (a == `MPM_ADDR_SAFETY) || (a == `MPM_ADDR_EXT) ||
                (a == `MPM_ADDR_FILTER) || (a == `MPM_ADDR_STATUS) ||
                (a == `MPM_ADDR_MASK) || (a == `MPM_ADDR_WINDOW);
        end
    endfunction

    // zero wait states; unmapped access answers with an error
    // a mapped but unaligned offset also answers with an error
    assign pready = 1'b1;
    assign addrOk = isMapped(paddr);
    assign pslverr = psel & penable & ~addrOk;
    assign wrEn = psel & penable & pwrite & addrOk;
    assign rdEn = psel & ~penable & ~pwrite;

    // async comparator: two flops before any use
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            compMeta <= 1'b0;
            compSync <= 1'b0;
        end else begin
            compMeta <= currentComparator;
            compSync <= compMeta;
        end
    end

    // comparator path: blanking, then the run-length filter
    mpm_blank_filter #(
        .STEP_CYC(STEP_CYC)
    ) i_mpm_blank_filter (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .pwmOnStart(pwmOnStart),
        .blankingWindowLength(comparatorFilterReg[2:0]),
        .feedbackSampleCount(comparatorFilterReg[6:4]),
        .compSync(compSync),
        .limitEvent(limitEvent)
    );

    // window runs only in current mode; held idle otherwise
    mpm_window_gen i_mpm_window_gen (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .run(currentModeSelect),
        .period(windowPeriod),
        .windowEnd(windowEnd)
    );

    // interrupt only when flag and mask bit both set
    assign climIrq = status[`MPM_ST_CURRENT_LIMIT_IRQ_ENABLE] & mask[`MPM_ST_CURRENT_LIMIT_IRQ_ENABLE];
    assign irq = climIrq | (status[`MPM_ST_WIN] & mask[`MPM_ST_WIN]);

    // register writes and hardware-set sticky flags
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            currentModeSelect <= 1'b0;
            currentLimitIrqEnable <= 1'b0;
            overcurrentActionSelect <= 1'b0;
            masterOutputEnable <= 1'b0;
            disabledStateSelect <= 1'b0;
            refEnable <= 3'h0;
            comparatorFilterReg <= `MPM_RST_FILTER;
            status <= 2'h0;
            mask <= 2'h0;
            windowPeriod <= `MPM_RST_WINDOW;
        end else begin
            if (wrEn) begin
                case (paddr)
                    `MPM_ADDR_CTRL_A: begin
                        currentModeSelect <= pwdata[`MPM_CA_MODE];
                        currentLimitIrqEnable <= pwdata[`MPM_CA_CLIMEN];
                    end
                    `MPM_ADDR_CTRL_B: begin
                        overcurrentActionSelect <= pwdata[`MPM_CB_OCV];
                    end
                    `MPM_ADDR_SAFETY: begin
                        masterOutputEnable <= pwdata[`MPM_SF_MOE];
                        disabledStateSelect <= pwdata[`MPM_SF_DISABLED_STATE_SELECT];
                    end
                    `MPM_ADDR_EXT: begin
                        refEnable <= pwdata[2:0];
                    end
                    `MPM_ADDR_FILTER: begin
                        comparatorFilterReg <= {1'b0, pwdata[6:4],
                            1'b0, pwdata[2:0]};
                    end
                    `MPM_ADDR_MASK: begin
                        mask <= pwdata[1:0];
                    end
                    `MPM_ADDR_WINDOW: begin
                        windowPeriod <= pwdata[15:0];
                    end
                    default: begin
                        windowPeriod <= windowPeriod;
                    end
                endcase
            end
            // write-one-to-clear, then hardware set wins
            status <= status & ~((wrEn && paddr == `MPM_ADDR_STATUS) ?
                pwdata[1:0] : 2'h0);
            if (limitEvent) begin
                status[`MPM_ST_CURRENT_LIMIT_IRQ_ENABLE] <= 1'b1;
            end
            if (windowEnd) begin
                status[`MPM_ST_WIN] <= 1'b1;
            end
            // overcurrent with action set: master enable drops
            // a software write in the same cycle loses to this clear
            if (limitEvent && !currentModeSelect && currentLimitIrqEnable &&
                    mask[`MPM_ST_CURRENT_LIMIT_IRQ_ENABLE] && overcurrentActionSelect) begin
                masterOutputEnable <= 1'b0;
            end
        end
    end

    // read data registered in setup phase
    // unmapped reads return zero
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
        end else if (rdEn) begin
            case (paddr)
                `MPM_ADDR_CTRL_A: prdata <= {30'h0, currentLimitIrqEnable,
                    currentModeSelect};
                `MPM_ADDR_CTRL_B: prdata <= {31'h0, overcurrentActionSelect};
                `MPM_ADDR_SAFETY: prdata <= {30'h0, disabledStateSelect,
                    masterOutputEnable};
                `MPM_ADDR_EXT: prdata <= {29'h0, refEnable};
                `MPM_ADDR_FILTER: prdata <= {24'h0, comparatorFilterReg};
                `MPM_ADDR_STATUS: prdata <= {30'h0, status};
                `MPM_ADDR_MASK: prdata <= {30'h0, mask};
                `MPM_ADDR_WINDOW: prdata <= {16'h0, windowPeriod};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // current-mode on/off sequencing
    always @* begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (windowEnd) begin
                    next_state = ST_ON; // on at window end
                end
            end
            ST_ON: begin
                // a window only dips the output for its one cycle, so
                // the on-phase resumes right after it ends
                if (limitEvent) begin
                    next_state = ST_OFF; // limit ends the on-phase
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    // state register and blanking hold
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_OFF;
            pwmOnStart <= 1'b1; // output is off in reset
        end else begin
            state <= currentModeSelect ? next_state : ST_OFF;
            // held through every off-time and released as the pwm turns
            // on, so the blanking window starts with the on-phase and no
            // stale off-time sample can cut a fresh pulse
            pwmOnStart <= ~next_pwm;
        end
    end

    // choose pwm source by mode
    always @* begin
        if (currentModeSelect) begin
            // window start cuts the on-phase for its own cycle
            next_pwm = (state == ST_ON) & ~limitEvent & ~windowEnd;
        end else begin
            // current loop cuts pwm while flag is set
            next_pwm = phaseUCompare & ~status[`MPM_ST_CURRENT_LIMIT_IRQ_ENABLE];
        end
    end

    // per channel drive: pwm on selected, reset state if disabled
    genvar i;
    generate
        for (i = 0; i < CHANNELS; i = i + 1) begin : gChan
            always @* begin
                if (!masterOutputEnable) begin
                    next_outputs[i] = 1'b0;
                    next_enables[i] = disabledStateSelect;
                end else begin
                    next_outputs[i] = channelSelect[i] & next_pwm;
                    next_enables[i] = 1'b1;
                end
            end
        end
    endgenerate

    // registered outputs
    // flops here so the pins never see decode glitches
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwmToChannels <= 1'b0;
            motorOutputChannels <= {CHANNELS{1'b0}};
            motorOutputEnable <= {CHANNELS{1'b0}};
            currentReferenceOut <= 1'b0;
        end else begin
            pwmToChannels <= next_pwm;
            motorOutputChannels <= next_outputs;
            motorOutputEnable <= next_enables;
            // reference only in current mode
            currentReferenceOut <= currentModeSelect &
                ((refEnable[`MPM_EX_PU] & phaseUCompare) |
                 (refEnable[`MPM_EX_PV] & phaseVCompare) |
                 (refEnable[`MPM_EX_PW] & phaseWCompare));
        end
    end
endmodule // mpm_pwm_manager

// ---- hw/mpm_window_gen.v ----
`timescale 1ns/1ps
`include "mpm_consts.vh"
// measurement window clock: pulses at each window end
module mpm_window_gen (
    input wire ref_clk,
    input wire reset_n,
    input wire run,
    input wire [15:0] period,
    output reg windowEnd
);
    reg [15:0] cnt; // cycles within current window

    // free count, wrap on programmed period
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 16'h0000;
            windowEnd <= 1'b0;
        end else if (!run) begin
            cnt <= 16'h0000;
            windowEnd <= 1'b0;
        end else if (cnt >= period) begin
            cnt <= 16'h0000;
            windowEnd <= 1'b1;
        end else begin
            cnt <= cnt + 16'h0001;
            windowEnd <= 1'b0;
        end
    end
endmodule // mpm_window_gen

// ---- shared/mpm_consts.vh ----
`ifndef MPM_CONSTS_VH
`define MPM_CONSTS_VH
// apb register byte offsets
`define MPM_ADDR_CTRL_A 12'h000
`define MPM_ADDR_CTRL_B 12'h004
`define MPM_ADDR_SAFETY 12'h008
`define MPM_ADDR_EXT 12'h00C
`define MPM_ADDR_FILTER 12'h010
`define MPM_ADDR_STATUS 12'h014
`define MPM_ADDR_MASK 12'h018
`define MPM_ADDR_WINDOW 12'h01C
// control a fields
`define MPM_CA_MODE 0
`define MPM_CA_CLIMEN 1
// control b fields
`define MPM_CB_OCV 0
// safety fields
`define MPM_SF_MOE 0
`define MPM_SF_DISABLED_STATE_SELECT 1
// extension fields
`define MPM_EX_PU 0
`define MPM_EX_PV 1
`define MPM_EX_PW 2
// filter fields: blanking [2:0], sample count [6:4]
`define MPM_FL_BLANK_LSB 0
`define MPM_FL_COUNT_LSB 4
// status and mask fields
`define MPM_ST_CURRENT_LIMIT_IRQ_ENABLE 0
`define MPM_ST_WIN 1
// blanking step of 0.5 us is two clocks of a 4 MHz periph clock
`define MPM_BLANK_STEP_NS 500
`define MPM_REF_PERIPH_MHZ 4
`define MPM_CLK_PERIOD_NS 5
// comparator sampled once per four clocks
`define MPM_SAMPLE_DIV 4
// reset values
`define MPM_RST_FILTER 8'h00
`define MPM_RST_WINDOW 16'h00C8
`endif

// ---- tb/mpm_pwm_manager_asserts.sv ----
`timescale 1ns/1ps
`include "mpm_consts.vh"
// port-level checks on the pwm manager
module mpm_pwm_manager_asserts #(
    parameter CHANNELS = 6
) (
    input wire ref_clk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire phaseUCompare,
    input wire phaseVCompare,
    input wire phaseWCompare,
    input wire currentComparator,
    input wire [CHANNELS-1:0] channelSelect,
    input wire pwmToChannels,
    input wire [CHANNELS-1:0] motorOutputEnable,
    input wire [CHANNELS-1:0] motorOutputChannels,
    input wire currentReferenceOut,
    input wire irq
);
    reg [7:0] cmpAge; // cycles since the comparator was last high
    wire access = psel && penable; // apb access phase
    wire maskWr = access && pwrite && paddr == `MPM_ADDR_MASK;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // saturating age, so stale comparator edges stop excusing irq
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) cmpAge <= 8'hFF;
        else if (currentComparator) cmpAge <= 8'h00;
        else if (cmpAge != 8'hFF) cmpAge <= cmpAge + 8'h01;
    end
    a_slverr_unmapped: assert property (access && paddr > 12'h01C |-> pslverr)
        else $error("no error response on unmapped address");
    a_slverr_mapped: assert property (access && paddr <= 12'h01C
        && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error response on mapped address");
    a_prdata_hold: assert property (!$past(psel && !penable && !pwrite)
        |-> $stable(prdata))
        else $error("read data moved without a read");
    a_irq_cause: assert property ($rose(irq) |->
        $past(maskWr) || cmpAge < 8'h40)
        else $error("irq rose without mask write or limit");
    a_irq_sync: assert property ($rose(currentComparator) && !irq
        |-> !irq [*3])
        else $error("irq faster than the synchroniser allows");
    a_reset_idle: assert property ($rose(reset_n) |->
        motorOutputEnable == '0 && !pwmToChannels)
        else $error("outputs not in reset state after reset");
    a_route_sel: assert property ($past(channelSelect) == channelSelect
        |-> (motorOutputChannels & ~channelSelect) == '0)
        else $error("pwm on an unselected channel");
    a_ref_phase: assert property (currentReferenceOut |->
        $past(phaseUCompare || phaseVCompare || phaseWCompare))
        else $error("reference high with no phase compare");
endmodule // mpm_pwm_manager_asserts

// ---- tb/mpm_sense_model.sv ----
`timescale 1ns/1ps
// far side: current-sense comparator and the inverter switch gates
module mpm_sense_model (
    input wire logic overLimit,
    input wire logic [5:0] drive,
    input wire logic [5:0] oe,
    output logic currentComparator,
    output wire [5:0] switchGate
);
    // comparator is analog, so its edge lands off the clock grid
    initial currentComparator = 1'b0;
    always @(overLimit) begin
        currentComparator <= #2 overLimit;
    end
    // no pull on a released gate: show the inverse so reliance shows
    genvar i;
    for (i = 0; i < 6; i = i + 1) begin : g_gate
        assign switchGate[i] = oe[i] ? drive[i] : ~drive[i];
    end
endmodule // mpm_sense_model

// ---- tb/test_motor_pwm_manager.sv ----
`timescale 1ns/1ps
`include "mpm_consts.vh"
// self-checking bench for the motor pwm manager
module test_motor_pwm_manager;
    localparam PERIPH = 20; // shrinks a blanking step to 20 clocks
    localparam STEP = `MPM_BLANK_STEP_NS * `MPM_REF_PERIPH_MHZ
        / PERIPH / `MPM_CLK_PERIOD_NS;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic er;
    logic phaseUCompare = 1'b0, phaseVCompare = 1'b0;
    logic phaseWCompare = 1'b0, overLimit = 1'b0;
    logic [5:0] channelSelect = 6'h00;
    wire [31:0] prdata;
    wire pready, pslverr, pwmToChannels, currentReferenceOut, irq;
    wire currentComparator;
    wire [5:0] motorOutputChannels, motorOutputEnable, switchGate;
    integer errCount = 0, cmpCount = 0, cyc = 0, span;
    always #2.5 ref_clk = ~ref_clk;
    mpm_pwm_manager #(.PERIPH_MHZ(PERIPH), .CHANNELS(6)) i_mpm_pwm_manager (
        .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .phaseUCompare(phaseUCompare),
        .phaseVCompare(phaseVCompare), .phaseWCompare(phaseWCompare),
        .currentComparator(currentComparator),
        .channelSelect(channelSelect), .pwmToChannels(pwmToChannels),
        .motorOutputChannels(motorOutputChannels),
        .motorOutputEnable(motorOutputEnable),
        .currentReferenceOut(currentReferenceOut), .irq(irq));
    mpm_sense_model i_mpm_sense_model (.overLimit(overLimit),
        .drive(motorOutputChannels), .oe(motorOutputEnable),
        .currentComparator(currentComparator), .switchGate(switchGate));
    task testDone;
        $display("checks %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard, well above the whole sequence
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errCount++;
            testDone;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            errCount++;
        end
    endtask
    // one apb transfer, held until pready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // bounded wait for the resulting pwm to reach a level
    task waitPwm(input logic v);
        span = 0;
        while (pwmToChannels !== v && span < 400) begin
            @(posedge ref_clk); span++;
        end
    endtask
    task tRegs;
        rdchk(`MPM_ADDR_FILTER, 32'h0);
        rdchk(`MPM_ADDR_WINDOW, 32'h000000C8);
        rdchk(`MPM_ADDR_SAFETY, 32'h0);
        apb(1'b0, 12'h040, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        chk(motorOutputEnable, 6'h00);
    endtask
    task tVoltage;
        channelSelect <= 6'h2D; phaseUCompare <= 1'b1;
        wr(`MPM_ADDR_SAFETY, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk(pwmToChannels, 1'b1);
        chk(motorOutputChannels, 6'h2D);
        phaseUCompare <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk({pwmToChannels, motorOutputChannels}, 7'h00);
        phaseUCompare <= 1'b1;
    endtask
    // four samples needed; action select set but limit enable off
    task tLimit;
        wr(`MPM_ADDR_FILTER, 32'h30);
        wr(`MPM_ADDR_CTRL_B, 32'h1);
        overLimit <= 1'b1;
        repeat (6) @(posedge ref_clk);
        apb(1'b0, `MPM_ADDR_STATUS, 32'h0);
        chk(rd[0], 1'b0);
        repeat (30) @(posedge ref_clk);
        apb(1'b0, `MPM_ADDR_STATUS, 32'h0);
        chk(rd[0], 1'b1);
        chk({irq, pwmToChannels}, 2'h0);
        chk(motorOutputEnable, 6'h3F);
        overLimit <= 1'b0;
        wr(`MPM_ADDR_MASK, 32'h1);
        @(posedge ref_clk);
        chk(irq, 1'b1);
        wr(`MPM_ADDR_STATUS, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk({irq, pwmToChannels}, 2'h1);
    endtask
    task tAction;
        wr(`MPM_ADDR_CTRL_A, 32'h2);
        wr(`MPM_ADDR_SAFETY, 32'h3);
        overLimit <= 1'b1;
        repeat (40) @(posedge ref_clk);
        overLimit <= 1'b0;
        chk(motorOutputEnable, 6'h3F);
        chk(switchGate, 6'h00);
        chk({irq, motorOutputChannels}, 7'h40);
        rdchk(`MPM_ADDR_SAFETY, 32'h2);
        wr(`MPM_ADDR_SAFETY, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk(motorOutputEnable, 6'h00);
        wr(`MPM_ADDR_CTRL_B, 32'h0);
    endtask
    // current mode: blanking of two steps, one sample to cut off
    task tCurrent;
        wr(`MPM_ADDR_STATUS, 32'h3);
        wr(`MPM_ADDR_CTRL_A, 32'h1);
        wr(`MPM_ADDR_EXT, 32'h1);
        wr(`MPM_ADDR_FILTER, 32'h02);
        wr(`MPM_ADDR_SAFETY, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk(currentReferenceOut, 1'b1);
        wr(`MPM_ADDR_EXT, 32'h2);
        repeat (2) @(posedge ref_clk);
        chk(currentReferenceOut, 1'b0);
        overLimit <= 1'b1;
        waitPwm(1'b0);
        waitPwm(1'b1);
        waitPwm(1'b0);
        chk(span >= 2 * STEP - 1 && span <= 2 * STEP + 12, 1'b1);
        overLimit <= 1'b0;
        rdchk(`MPM_ADDR_STATUS, 32'h3);
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        tRegs;
        tVoltage;
        tLimit;
        tAction;
        tCurrent;
        testDone;
    end
endmodule // test_motor_pwm_manager
bind mpm_pwm_manager mpm_pwm_manager_asserts #(.CHANNELS(CHANNELS)) u_chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
    .phaseUCompare(phaseUCompare), .phaseVCompare(phaseVCompare),
    .phaseWCompare(phaseWCompare), .currentComparator(currentComparator),
    .channelSelect(channelSelect), .pwmToChannels(pwmToChannels),
    .motorOutputEnable(motorOutputEnable),
    .motorOutputChannels(motorOutputChannels),
    .currentReferenceOut(currentReferenceOut), .irq(irq));
